// [src/dl_ctrl.sv]
// Data link transmit/receive control for HDLC controller 1
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
module dl_ctrl
	import dl_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Register port
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Outbound message octets
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire tx_word_t tx_word_i,
	// Outbound bit pattern octet
	input wire logic [7:0] pat_octet_i,
	// Serial bit enable and line bits
	input wire logic bit_en_i,
	output logic tx_bit_o,
	// Received octets from the deframer
	input wire logic rx_valid_i,
	input wire rx_word_t rx_word_i,
	output logic rx_keep_o,
	output logic rx_drop_o,
	output logic rx_fcs_err_o,
	// Mode outputs
	output logic mode_msg_o
);
	// ****************************************
	// Control register
	// ****************************************
	logic [7:0] ctl_r; // Data link control 1
	logic [7:0] rdata_r; // Read data
	logic send_pat_r; // Pattern send request pending
	wire wr_ctl = wr_i && (addr_i == DLC1_OFS);
	// Decoded control fields
	wire msg_mode = ctl_r[MODE_BIT];
	wire auto_abort = !ctl_r[AABORT_BIT];
	wire idle_fill = msg_mode && ctl_r[IDLE_BIT];
	wire fcs_on = msg_mode && ctl_r[FCS_EN_BIT];
	wire force_abort = ctl_r[FABORT_BIT];
	wire rx_chk_on = !ctl_r[RXCHK_BIT];
	wire discard_on = ctl_r[DISC_BIT];

	// ****************************************
	// Transmit state
	// ****************************************
	tx_state_t st_r, st_nxt;
	logic [7:0] sh_r; // Octet being shifted
	logic [2:0] bi_r; // Bit index
	logic [15:0] tcrc_r; // Transmit check register
	logic in_frame_r; // Message frame under way
	logic [2:0] ones_r; // Run of ones for stuffing
	wire fifo_v;
	wire tx_word_t fifo_w;
	wire stuff = (st_r == TX_DATA || st_r == TX_CRC1 || st_r == TX_CRC2) && (ones_r == 3'd5);
	wire octet_end = bit_en_i && !stuff && (bi_r == BIT_LAST);
	wire cur_bit = sh_r[bi_r];

	// Check register step over one bit
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		crc_step = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
	endfunction : crc_step

	// Check register with the bit now leaving folded in, so the first check octet covers the whole frame
	wire [15:0] tcrc_now = (st_r == TX_DATA) ? crc_step(tcrc_r, cur_bit) : tcrc_r;

	// Register read mux and write
	assign mode_msg_o = msg_mode;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctl_r <= DLC1_RST;
			rdata_r <= RD_ZERO;
			send_pat_r <= 1'b0;
		end else begin
			if (wr_ctl) ctl_r <= {1'b0, wdata_i[6:0]};
			if (wr_ctl && !wdata_i[MODE_BIT]) send_pat_r <= 1'b1;
			else if (octet_end && st_r == TX_IDLE && !msg_mode) send_pat_r <= 1'b0;
			if (!rd_i) rdata_r <= RD_ZERO;
			else if (addr_i == DLC1_OFS) rdata_r <= ctl_r;
			else if (addr_i == TXSTAT_OFS) rdata_r <= {3'b0, st_r};
			else if (addr_i == RXSTAT_OFS) rdata_r <= {5'b0, rx_fcs_err_o, rx_drop_o, rx_keep_o};
			else rdata_r <= RD_ZERO;
		end
	end
	assign rdata_o = rdata_r;

	// Next octet source selection
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			TX_IDLE: st_nxt = (fifo_v && msg_mode && !idle_fill) ? TX_DATA : TX_IDLE;
			TX_DATA: begin
				if (!msg_mode) st_nxt = auto_abort ? TX_ABRT : TX_IDLE;
				else if (idle_fill) st_nxt = TX_IDLE;
				else if (!in_frame_r) st_nxt = fcs_on ? TX_CRC1 : TX_IDLE;
				else if (!fifo_v) st_nxt = TX_ABRT;
			end
			TX_CRC1: st_nxt = idle_fill ? TX_IDLE : TX_CRC2;
			TX_CRC2: st_nxt = TX_IDLE;
			TX_ABRT: st_nxt = TX_IDLE;
			default: st_nxt = TX_IDLE;
		endcase
		if (force_abort) st_nxt = TX_ABRT;
	end

	// Octet loader: pop message words only at octet boundaries
	wire load_data = octet_end && (st_nxt == TX_DATA);
	logic fifo_rdy; // Fill-side ready, registered inside the buffer
	assign tx_ready_o = fifo_rdy;
	// Transmit buffer between the octet source and the shifter
	dl_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.in_valid_i(tx_valid_i),
		.in_ready_o(fifo_rdy),
		.in_data_i(tx_word_i),
		.out_valid_o(fifo_v),
		.out_ready_i(load_data),
		.out_data_o(fifo_w)
	);

	// Next octet value
	logic [7:0] oct_nxt;
	always_comb begin
		case (st_nxt)
			TX_DATA: oct_nxt = fifo_w.data;
			TX_CRC1: oct_nxt = ~tcrc_now[7:0];
			TX_CRC2: oct_nxt = ~tcrc_r[15:8];
			TX_ABRT: oct_nxt = ABORT_OCTET;
			default: oct_nxt = (!msg_mode && send_pat_r) ? pat_octet_i : FLAG_OCTET;
		endcase
	end

	// Serial shifter with zero insertion and check update
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r <= TX_IDLE;
			sh_r <= FLAG_OCTET;
			bi_r <= 3'h0;
			tcrc_r <= CRC_INIT;
			in_frame_r <= 1'b0;
			ones_r <= 3'h0;
			tx_bit_o <= 1'b0;
		end else if (bit_en_i) begin
			tx_bit_o <= stuff ? 1'b0 : cur_bit;
			ones_r <= (stuff || !cur_bit) ? 3'h0 : ones_r + 3'h1;
			if (!stuff) begin
				bi_r <= bi_r + 3'h1;
				if (st_r == TX_DATA) tcrc_r <= crc_step(tcrc_r, cur_bit);
				if (octet_end) begin
					st_r <= st_nxt;
					sh_r <= oct_nxt;
					if (st_nxt != TX_DATA && st_nxt != TX_CRC1 && st_nxt != TX_CRC2) ones_r <= 3'h0;
					if (st_r != TX_DATA && st_nxt == TX_DATA) tcrc_r <= CRC_INIT;
					if (st_nxt == TX_DATA) in_frame_r <= !fifo_w.eof;
				end
			end
		end
	end

	// ****************************************
	// Receive check and duplicate discard
	// ****************************************
	logic [15:0] rcrc_r; // Receive check register
	logic [15:0] hsum_r, csum_r; // Held and current frame signatures
	logic [7:0] len_r, hlen_r; // Current and held lengths
	logic keep_r, drop_r, err_r;
	// Receive check over one octet, lsb first
	logic [15:0] rcrc_nxt;
	always_comb begin
		rcrc_nxt = rx_word_i.sof ? CRC_INIT : rcrc_r;
		for (int i = 0; i < 8; i++) rcrc_nxt = crc_step(rcrc_nxt, rx_word_i.data[i]);
	end
	// Rolling signature and length of the current frame
	wire [15:0] csum_nxt = {(rx_word_i.sof ? 16'h0 : csum_r) ^ {8'h0, rx_word_i.data}} << 1 |
		{15'h0, (rx_word_i.sof ? 1'b0 : csum_r[15])};
	wire [7:0] len_nxt = rx_word_i.sof ? 8'h1 : len_r + 8'h1;
	// Verdict terms at frame end
	wire bad = rx_chk_on && (rcrc_nxt != CRC_GOOD);
	wire dup = discard_on && (csum_nxt == hsum_r) && (len_nxt == hlen_r);

	// Frame end verdict
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rcrc_r <= CRC_INIT;
			csum_r <= 16'h0;
			hsum_r <= 16'h0;
			len_r <= 8'h0;
			hlen_r <= 8'h0;
			keep_r <= 1'b0;
			drop_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			keep_r <= 1'b0;
			drop_r <= 1'b0;
			err_r <= 1'b0;
			if (rx_valid_i) begin
				rcrc_r <= rcrc_nxt;
				csum_r <= csum_nxt;
				len_r <= len_nxt;
				if (rx_word_i.eof) begin
					err_r <= bad;
					drop_r <= bad || dup;
					keep_r <= !bad && !dup;
					if (!bad && !dup) begin
						hsum_r <= csum_nxt;
						hlen_r <= len_nxt;
					end
				end
			end
		end
	end
	assign rx_keep_o = keep_r;
	assign rx_drop_o = drop_r;
	assign rx_fcs_err_o = err_r;

	// ****************************************
	// Assertions
	// ****************************************
	// Each property watches one rule: transmit rules at the octet boundary, the others at a register write or read, a frame end, reset or every clock
	idle_flag_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(octet_end && idle_fill && !force_abort && st_r != TX_DATA) |=> (sh_r == FLAG_OCTET))
		else $error("idle fill did not load flag");
	forced_abort_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(octet_end && force_abort) |=> (st_r == TX_ABRT && sh_r == ABORT_OCTET))
		else $error("forced abort not sent");
	auto_abort_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(octet_end && st_r == TX_DATA && !msg_mode && auto_abort) |=> (st_r == TX_ABRT))
		else $error("auto abort missing");
	no_abort_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(octet_end && st_r == TX_DATA && !msg_mode && !auto_abort && !force_abort) |=> (st_r == TX_IDLE))
		else $error("abort sent while disabled");
	rx_check_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(rx_valid_i && rx_word_i.eof && !rx_chk_on) |=> !rx_fcs_err_o)
		else $error("check error while disabled");
	dup_keep_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(rx_valid_i && rx_word_i.eof && !discard_on && !bad) |=> rx_keep_o)
		else $error("frame dropped with discard off");
	mode_pattern_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(octet_end && !msg_mode && st_r != TX_CRC1) |=> (st_r != TX_CRC1 && st_r != TX_DATA))
		else $error("frame or check octet started in pattern mode");
	pattern_idle_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(octet_end && !msg_mode && ctl_r[IDLE_BIT] && st_r == TX_IDLE && send_pat_r && !force_abort)
		|=> (sh_r == $past(pat_octet_i)))
		else $error("idle bit blocked pattern octet");
	reset_zero_a: assert property (@(posedge clk_i)
		$rose(arst_n_i) |-> (ctl_r == DLC1_RST))
		else $error("control not zero after reset");
	bit7_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ctl_r[7] == 1'b0)
		else $error("reserved bit stored");
	crc_follow_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(octet_end && st_r == TX_DATA && msg_mode && !idle_fill && !in_frame_r && fcs_on && !force_abort)
		|=> (st_r == TX_CRC1) ##0 (sh_r == ~$past(tcrc_now[7:0])))
		else $error("check octet not appended");
	pat_send_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(wr_ctl && !wdata_i[MODE_BIT]) |=> send_pat_r)
		else $error("pattern request lost");

	// Transmit flag fill, check octets and pattern request
	flag_fill_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(octet_end && st_r == TX_IDLE && msg_mode && !fifo_v && !force_abort) |=> (sh_r == FLAG_OCTET))
		else $error("no flag while nothing waits");
	crc_final_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(octet_end && st_r == TX_CRC1 && !idle_fill && !force_abort)
		|=> (st_r == TX_CRC2) ##0 (sh_r == ~$past(tcrc_r[15:8])))
		else $error("second check octet wrong");
	no_crc_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(octet_end && st_r == TX_DATA && msg_mode && !idle_fill && !in_frame_r && !fcs_on && !force_abort)
		|=> (st_r == TX_IDLE))
		else $error("check octet sent while append off");
	pat_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(octet_end && st_r == TX_IDLE && !msg_mode && !wr_ctl) |=> !send_pat_r)
		else $error("pattern request not consumed");

	// Register port answers
	rd_ctl_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(rd_i && addr_i == DLC1_OFS) |=> (rdata_o == $past(ctl_r)))
		else $error("control read back wrong");
	mode_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		wr_ctl |=> (mode_msg_o == $past(wdata_i[MODE_BIT])))
		else $error("mode output not following write");

	// Receive verdicts
	verdict_one_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(rx_valid_i && rx_word_i.eof) |=> (rx_keep_o != rx_drop_o))
		else $error("frame end without exactly one verdict");
endmodule : dl_ctrl

// [src/dl_ctrl_pkg.sv]
// Package: register map, field positions, reset values, symbols and carriers of the data link controller
package dl_ctrl_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] DLC1_OFS = 4'h0; // Data link control 1
	localparam logic [3:0] TXSTAT_OFS = 4'h1; // Transmit status, read only
	localparam logic [3:0] RXSTAT_OFS = 4'h2; // Receive status, read only
	localparam logic [7:0] DLC1_RST = 8'h00; // Control reset value
	localparam logic [7:0] RD_ZERO = 8'h00; // Unmapped read answer

	// ****************************************
	// Field positions of data link control 1
	// ****************************************
	localparam int MODE_BIT = 0; // Message frame / bit pattern select
	localparam int FCS_EN_BIT = 1; // Transmit check append
	localparam int IDLE_BIT = 2; // Idle flag fill
	localparam int FABORT_BIT = 3; // Forced abort
	localparam int DISC_BIT = 4; // Duplicate discard
	localparam int RXCHK_BIT = 5; // Receive check disable
	localparam int AABORT_BIT = 6; // Automatic abort disable

	// ****************************************
	// Symbols and counts
	// ****************************************
	localparam logic [7:0] FLAG_OCTET = 8'h7E; // Flag octet
	localparam logic [7:0] ABORT_OCTET = 8'hFE; // Zero then seven ones, lsb first
	localparam logic [15:0] CRC_INIT = 16'hFFFF; // Check register preset
	localparam logic [15:0] CRC_POLY = 16'h8408; // Reflected CCITT polynomial
	localparam logic [15:0] CRC_GOOD = 16'hF0B8; // Residue of a good frame
	localparam logic [2:0] BIT_LAST = 3'h7; // Last bit index of an octet
	localparam int FIFO_DEPTH = 16; // Transmit buffer depth

	// Transmit octet source
	typedef enum logic [4:0] {
		TX_IDLE = 5'b00001,
		TX_DATA = 5'b00010,
		TX_CRC1 = 5'b00100,
		TX_CRC2 = 5'b01000,
		TX_ABRT = 5'b10000
	} tx_state_t;

	// Transmit word: data octet with end of frame mark
	typedef struct packed {
		logic eof;
		logic [7:0] data;
	} tx_word_t;

	// Receive octet with frame boundaries
	typedef struct packed {
		logic sof;
		logic eof;
		logic [7:0] data;
	} rx_word_t;

endpackage : dl_ctrl_pkg

// [src/dl_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module dl_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH]; // Storage
	logic [AW:0] wp_r, rp_r; // Pointers with wrap bit
	logic not_full_r; // Registered fill-side ready
	logic [AW:0] wp_nxt, rp_nxt; // Pointers after this cycle
	wire push = in_valid_i & in_ready_o;
	wire pop = out_valid_o & out_ready_i;
	assign wp_nxt = wp_r + {{AW{1'b0}}, push};
	assign rp_nxt = rp_r + {{AW{1'b0}}, pop};
	// Ready comes from a flop, so the fill side sees no combinational path
	assign in_ready_o = not_full_r;
	assign out_valid_o = (wp_r != rp_r);
	assign out_data_o = mem_r[rp_r[AW-1:0]];
	// Pointer update
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp_r <= '0;
			rp_r <= '0;
			not_full_r <= 1'b1;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			// Full once the next pointers meet with opposite wrap bits
			not_full_r <= !((wp_nxt[AW-1:0] == rp_nxt[AW-1:0]) && (wp_nxt[AW] != rp_nxt[AW]));
		end
	end
	// Storage write
	always_ff @(posedge clk_i) begin
		if (push) mem_r[wp_r[AW-1:0]] <= in_data_i;
	end
endmodule : dl_fifo

// [verif/dl_remote.sv]
// Remote end model: paces line bits and watches the received bit stream
`timescale 1ns/10ps
module dl_remote (
	// Clock
	input wire logic clk_i,
	// Line side
	output logic bit_en_o,
	input wire logic line_bit_i,
	// Monitor control and counts
	input wire logic clr_i,
	input wire logic [7:0] want_i,
	output int flags_o,
	output int hits_o,
	output int ones_o
);
	logic [1:0] div_r = 2'h0; // Bit pacing divider
	logic [7:0] win_r = 8'h00; // Last eight line bits, lsb first
	int run_r = 0; // Current run of ones
	logic [7:0] win_nxt; // Window with the bit now on the line
	localparam logic [7:0] FLAG_W = 8'h7E; // Flag octet on the wire
	assign win_nxt = {line_bit_i, win_r[7:1]};
	assign bit_en_o = (div_r == 2'h3);
	// One line bit every fourth clock
	always_ff @(posedge clk_i) begin
		div_r <= div_r + 2'h1;
	end
	// Count flags, wanted octets and the longest ones run
	always_ff @(posedge clk_i) begin
		if (clr_i) begin
			flags_o <= 0;
			hits_o <= 0;
			ones_o <= 0;
			run_r <= 0;
		end else if (bit_en_o) begin
			win_r <= win_nxt;
			run_r <= line_bit_i ? run_r + 1 : 0;
			if (line_bit_i && run_r + 1 > ones_o) ones_o <= run_r + 1;
			if (win_nxt == FLAG_W) flags_o <= flags_o + 1;
			if (win_nxt == want_i) hits_o <= hits_o + 1;
		end
	end
endmodule : dl_remote

// [verif/tb_dl_ctrl.sv]
// Testbench of the data link control block
`timescale 1ns/10ps
module tb_dl_ctrl
	import dl_ctrl_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	logic clk_i = 1'b0, arst_n_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o, pat_octet_i = 8'h00, rv;
	logic wr_i = 1'b0, rd_i = 1'b0, tx_valid_i = 1'b0, tx_ready_o, bit_en_i, tx_bit_o;
	logic rx_valid_i = 1'b0, rx_keep_o, rx_drop_o, rx_fcs_err_o, mode_msg_o, clr_i = 1'b1;
	logic k, d, e, f; // Receive verdict seen, transmit state found
	logic [2:0] idx = 3'h0; // Outbound frame position
	tx_word_t tx_word_i;
	rx_word_t rx_word_i = '0;
	int flags, hits, ones, fail_count = 0, comparisons = 0;
	typedef struct { logic [7:0] w; logic [7:0] r; } row_t;
	row_t rows [4] = '{'{8'hFF, 8'h7F}, '{8'h55, 8'h55}, '{8'hAA, 8'h2A}, '{8'h00, 8'h00}};
	// Eight zero octets, the eighth marking the frame end, repeated
	assign tx_word_i = '{eof: (idx == 3'h7), data: 8'h00};
	always @(posedge clk_i) if (tx_valid_i && tx_ready_o) idx <= idx + 3'h1;
	initial forever #12.5 clk_i = ~clk_i;
	dl_ctrl dl_ctrl_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_word_i(tx_word_i),
		.pat_octet_i(pat_octet_i), .bit_en_i(bit_en_i), .tx_bit_o(tx_bit_o), .rx_valid_i(rx_valid_i),
		.rx_word_i(rx_word_i), .rx_keep_o(rx_keep_o), .rx_drop_o(rx_drop_o), .rx_fcs_err_o(rx_fcs_err_o),
		.mode_msg_o(mode_msg_o));
	dl_remote dl_remote_inst (.clk_i(clk_i), .bit_en_o(bit_en_i), .line_bit_i(tx_bit_o), .clr_i(clr_i),
		.want_i(pat_octet_i), .flags_o(flags), .hits_o(hits), .ones_o(ones));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			fail_count++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i) begin addr_i <= a; wdata_i <= v; wr_i <= 1'b1; end
		@(posedge clk_i) wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk_i) begin addr_i <= a; rd_i <= 1'b1; end
		@(posedge clk_i) rd_i <= 1'b0;
		@(negedge clk_i) rv = rdata_o;
	endtask : rd
	// Read the transmit state up to 300 times; report whether s turned up
	task automatic poll(input logic [4:0] s, output logic seen);
		seen = 1'b0;
		for (int i = 0; i < 300 && !seen; i++) begin
			rd(TXSTAT_OFS);
			seen = (rv[4:0] == s);
		end
	endtask : poll
	// Let the octet in flight finish, clear the remote counts, then let n line bits pass
	task automatic watch(input int n);
		repeat (64) @(posedge clk_i);
		@(posedge clk_i) clr_i <= 1'b1;
		@(posedge clk_i) clr_i <= 1'b0;
		repeat (4 * n) @(posedge clk_i);
	endtask : watch
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] v);
		logic [15:0] x;
		x = c ^ {8'h00, v};
		for (int i = 0; i < 8; i++) x = x[0] ? (x >> 1) ^ CRC_POLY : x >> 1;
		return x;
	endfunction : crc_step
	// Three octets and their check octets, optionally corrupted
	task automatic rx_send(input logic [7:0] s, input logic bad);
		logic [15:0] c;
		logic [7:0] b [5];
		c = CRC_INIT;
		for (int i = 0; i < 3; i++) begin b[i] = s + 8'(i); c = crc_step(c, b[i]); end
		c = ~c;
		b[3] = c[7:0] ^ {7'h00, bad};
		b[4] = c[15:8];
		for (int i = 0; i < 5; i++) @(posedge clk_i) begin
			rx_valid_i <= 1'b1;
			rx_word_i <= '{sof: (i == 0), eof: (i == 4), data: b[i]};
		end
		@(posedge clk_i) rx_valid_i <= 1'b0;
		@(negedge clk_i) begin k = rx_keep_o; d = rx_drop_o; e = rx_fcs_err_o; end
	endtask : rx_send
	task automatic close_out();
		if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd(DLC1_OFS); chk(rv, 8'h00);
		chk(mode_msg_o, 1'b0);
		foreach (rows[i]) begin
			wr(DLC1_OFS, rows[i].w);
			rd(DLC1_OFS); chk(rv, rows[i].r);
			chk(mode_msg_o, rows[i].r[0]);
		end
		rd(4'hF); chk(rv, 8'h00);
		wr(DLC1_OFS, 8'h01);
		watch(64); chk(flags >= 6, 1'b1);
		wr(DLC1_OFS, 8'h09);
		watch(48); chk(ones >= 7, 1'b1);
		tx_valid_i <= 1'b1;
		wr(DLC1_OFS, 8'h05);
		watch(64); chk(flags >= 6, 1'b1);
		chk(ones >= 7, 1'b0);
		wr(DLC1_OFS, 8'h01);
		watch(24);
		poll(TX_DATA, f); chk(f, 1'b1);
		if (!f) close_out();
		wr(DLC1_OFS, 8'h00);
		repeat (160) @(posedge clk_i);
		chk(ones >= 7, 1'b1);
		wr(DLC1_OFS, 8'h41);
		watch(24);
		poll(TX_DATA, f); chk(f, 1'b1);
		if (!f) close_out();
		wr(DLC1_OFS, 8'h40);
		repeat (160) @(posedge clk_i);
		chk(ones >= 7, 1'b0);
		wr(DLC1_OFS, 8'h03);
		poll(TX_CRC1, f); chk(f, 1'b1);
		if (!f) close_out();
		wr(DLC1_OFS, 8'h01);
		repeat (80) @(posedge clk_i);
		poll(TX_CRC1, f); chk(f, 1'b0);
		tx_valid_i <= 1'b0;
		pat_octet_i <= 8'hA5;
		clr_i <= 1'b1;
		wr(DLC1_OFS, 8'h04);
		clr_i <= 1'b0;
		repeat (200) @(posedge clk_i);
		chk(hits >= 1, 1'b1);
		wr(DLC1_OFS, 8'h00);
		rx_send(8'h10, 1'b0); chk({k, e}, 2'b10);
		rx_send(8'h20, 1'b1); chk(e, 1'b1);
		wr(DLC1_OFS, 8'h20);
		rx_send(8'h20, 1'b1); chk({k, e}, 2'b10);
		wr(DLC1_OFS, 8'h10);
		rx_send(8'h30, 1'b0); chk({k, d}, 2'b10);
		rx_send(8'h30, 1'b0); chk({k, d}, 2'b01);
		wr(DLC1_OFS, 8'h00);
		rx_send(8'h30, 1'b0); chk({k, d}, 2'b10);
		close_out();
	end
endmodule : tb_dl_ctrl
